// File: acrs_consts.svh
// register offsets, reset values and field positions of the configuration slice
`ifndef ACRS_CONSTS_SVH
`define ACRS_CONSTS_SVH
`define ACRS_ADDR_W         8
`define ACRS_ADDR_FS_A_LO   8'h30
`define ACRS_ADDR_FS_A_HI   8'h31
`define ACRS_ADDR_FS_B_LO   8'h32
`define ACRS_ADDR_FS_B_HI   8'h33
`define ACRS_ADDR_REF_BYP   8'h38
`define ACRS_ADDR_TS_CTRL   8'h3b
`define ACRS_ADDR_PREEMPH   8'h48
`define ACRS_ADDR_IN_SEL    8'h60
`define ACRS_ADDR_CAL_EN    8'h61
`define ACRS_ADDR_CALIBRATION_CONFIG_ZERO  8'h62
`define ACRS_ADDR_CAL_STAT  8'h6a
`define ACRS_ADDR_CAL_PIN   8'h6b
`define ACRS_ADDR_CAL_KICK  8'h6c
`define ACRS_ADDR_LOW_POWER_BACKGROUND_CAL    8'h6e
`define ACRS_ADDR_CAL_DEN   8'h70
`define ACRS_ADDR_CAL_DATA  8'h71
`define ACRS_RST_FS         16'ha000
`define ACRS_RST_FS_HI      8'ha0
`define ACRS_RST_FS_LO      8'h00
`define ACRS_RST_ZERO       8'h00
`define ACRS_RST_ONE        8'h01
`define ACRS_RST_LOW_POWER_BACKGROUND_CAL     8'h88
`define ACRS_BIT_REF_BYP    0
`define ACRS_BIT_TS_RECV    0
`define ACRS_BIT_TS_PECL    1
`define ACRS_PE_MSB         3
`endif

// File: acrs_pkg.sv
// types shared by the configuration slice
`default_nettype none
package acrs_pkg;
  // one register port access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acrs_bus_s;
  // control outputs toward the analog and serializer blocks
  typedef struct packed {
    logic [15:0] fs_trim_a;
    logic [15:0] fs_trim_b;
    logic        ref_bypass;
    logic        ts_recv_on;
    logic        ts_pecl_sel;
    logic [3:0]  preemph;
  } acrs_ctrl_s;
endpackage : acrs_pkg
`default_nettype wire

// File: acrs_regs.sv
// configuration register slice: trims, reference bypass, timestamp, lanes, calibration
//
// Strobed register access was left to the implementer.
`include "acrs_consts.svh"
`default_nettype none
module acrs_regs
  import acrs_pkg::*;
#(
  parameter int ADDR_W = `ACRS_ADDR_W
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [7:0]        i_cal_state,
  output logic      [7:0]        o_rdata,
  output acrs_ctrl_s             o_ctrl,
  output logic      [7:0]        o_in_sel,
  output logic      [7:0]        o_cal_en,
  output logic      [7:0]        o_calibration_config_zero,
  output logic      [7:0]        o_cal_pin,
  output logic      [7:0]        o_cal_kick,
  output logic      [7:0]        o_low_power_background_cal,
  output logic      [7:0]        o_cal_den,
  output logic      [7:0]        o_cal_data
);

  // decode only covers an 8-bit map
  if (ADDR_W != 8) begin : g_chk
    $error("acrs_regs: ADDR_W must be 8");
  end

  typedef enum logic [3:0] {
    R_FS_A_LO, R_FS_A_HI, R_FS_B_LO, R_FS_B_HI, R_REF, R_TS, R_PE, R_INSEL,
    R_CEN, R_CFG0, R_CPIN, R_KICK, R_CLP, R_CDEN, R_CDATA, R_NONE
  } acrs_reg_e;

  // address to register index, shared by write and read paths
  function automatic acrs_reg_e acrs_decode(input logic [7:0] a);
    case (a)
      `ACRS_ADDR_FS_A_LO:  acrs_decode = R_FS_A_LO;
      `ACRS_ADDR_FS_A_HI:  acrs_decode = R_FS_A_HI;
      `ACRS_ADDR_FS_B_LO:  acrs_decode = R_FS_B_LO;
      `ACRS_ADDR_FS_B_HI:  acrs_decode = R_FS_B_HI;
      `ACRS_ADDR_REF_BYP:  acrs_decode = R_REF;
      `ACRS_ADDR_TS_CTRL:  acrs_decode = R_TS;
      `ACRS_ADDR_PREEMPH:  acrs_decode = R_PE;
      `ACRS_ADDR_IN_SEL:   acrs_decode = R_INSEL;
      `ACRS_ADDR_CAL_EN:   acrs_decode = R_CEN;
      `ACRS_ADDR_CALIBRATION_CONFIG_ZERO: acrs_decode = R_CFG0;
      `ACRS_ADDR_CAL_PIN:  acrs_decode = R_CPIN;
      `ACRS_ADDR_CAL_KICK: acrs_decode = R_KICK;
      `ACRS_ADDR_LOW_POWER_BACKGROUND_CAL:   acrs_decode = R_CLP;
      `ACRS_ADDR_CAL_DEN:  acrs_decode = R_CDEN;
      `ACRS_ADDR_CAL_DATA: acrs_decode = R_CDATA;
      default:             acrs_decode = R_NONE;
    endcase
  endfunction : acrs_decode

  // byte storage indexed by register; R_NONE has no storage
  logic [7:0] regs      [15];
  logic [7:0] next_regs [15];
  logic [7:0] next_rdata;
  acrs_reg_e  wsel;
  acrs_reg_e  rsel;

  // write path: full bytes stored, reserved bits kept as written
  always_comb begin
    wsel = acrs_decode(i_addr);
    for (int k = 0; k < 15; k++) begin
      next_regs[k] = regs[k];
    end
    if (i_wr && wsel != R_NONE) begin
      next_regs[wsel] = i_wdata;
    end
  end

  // read path: unmapped reads zero, status reads the live calibration state
  always_comb begin
    rsel       = acrs_decode(i_addr);
    next_rdata = 8'h00;
    if (i_rd) begin
      if (i_addr == `ACRS_ADDR_CAL_STAT) begin
        next_rdata = i_cal_state;
      end else if (rsel != R_NONE) begin
        next_rdata = regs[rsel];
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // registers; undefined-reset data register is cleared anyway for determinism
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      regs[R_FS_A_LO] <= `ACRS_RST_FS_LO;
      regs[R_FS_A_HI] <= `ACRS_RST_FS_HI;
      regs[R_FS_B_LO] <= `ACRS_RST_FS_LO;
      regs[R_FS_B_HI] <= `ACRS_RST_FS_HI;
      regs[R_REF]     <= `ACRS_RST_ZERO;
      regs[R_TS]      <= `ACRS_RST_ZERO;
      regs[R_PE]      <= `ACRS_RST_ZERO;
      regs[R_INSEL]   <= `ACRS_RST_ONE;
      regs[R_CEN]     <= `ACRS_RST_ONE;
      regs[R_CFG0]    <= `ACRS_RST_ONE;
      regs[R_CPIN]    <= `ACRS_RST_ZERO;
      regs[R_KICK]    <= `ACRS_RST_ONE;
      regs[R_CLP]     <= `ACRS_RST_LOW_POWER_BACKGROUND_CAL;
      regs[R_CDEN]    <= `ACRS_RST_ZERO;
      regs[R_CDATA]   <= `ACRS_RST_ZERO;
      o_rdata         <= `ACRS_RST_ZERO;
    end else begin
      for (int k = 0; k < 15; k++) begin
        regs[k] <= next_regs[k];
      end
      o_rdata <= next_rdata;
    end
  end

  // control outputs registered from the next-state array
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ctrl     <= '{fs_trim_a: `ACRS_RST_FS, fs_trim_b: `ACRS_RST_FS, default: '0};
      o_in_sel   <= `ACRS_RST_ONE;
      o_cal_en   <= `ACRS_RST_ONE;
      o_calibration_config_zero <= `ACRS_RST_ONE;
      o_cal_pin  <= `ACRS_RST_ZERO;
      o_cal_kick <= `ACRS_RST_ONE;
      o_low_power_background_cal   <= `ACRS_RST_LOW_POWER_BACKGROUND_CAL;
      o_cal_den  <= `ACRS_RST_ZERO;
      o_cal_data <= `ACRS_RST_ZERO;
    end else begin
      o_ctrl.fs_trim_a   <= {next_regs[R_FS_A_HI], next_regs[R_FS_A_LO]};
      o_ctrl.fs_trim_b   <= {next_regs[R_FS_B_HI], next_regs[R_FS_B_LO]};
      o_ctrl.ref_bypass  <= next_regs[R_REF][`ACRS_BIT_REF_BYP];
      o_ctrl.ts_recv_on  <= next_regs[R_TS][`ACRS_BIT_TS_RECV];
      o_ctrl.ts_pecl_sel <= next_regs[R_TS][`ACRS_BIT_TS_PECL];
      o_ctrl.preemph     <= next_regs[R_PE][`ACRS_PE_MSB:0];
      o_in_sel   <= next_regs[R_INSEL];
      o_cal_en   <= next_regs[R_CEN];
      o_calibration_config_zero <= next_regs[R_CFG0];
      o_cal_pin  <= next_regs[R_CPIN];
      o_cal_kick <= next_regs[R_KICK];
      o_low_power_background_cal   <= next_regs[R_CLP];
      o_cal_den  <= next_regs[R_CDEN];
      o_cal_data <= next_regs[R_CDATA];
    end
  end

  // trims below 0x2000 are stored as written; software keeps the floor

  // write to bypass shows on the output one edge later
  AST_REF_BYPASS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_REF_BYP) |=> o_ctrl.ref_bypass == $past(i_wdata[0]))
    else $error("reference bypass not following write");

  AST_TS_RECV: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_TS_CTRL) |=> o_ctrl.ts_recv_on == $past(i_wdata[0]))
    else $error("timestamp receiver enable wrong");

  AST_TS_PECL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_TS_CTRL) |=> o_ctrl.ts_pecl_sel == $past(i_wdata[1]))
    else $error("timestamp pecl select wrong");

  AST_PREEMPH: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_PREEMPH) |=> o_ctrl.preemph == $past(i_wdata[3:0]))
    else $error("pre-emphasis not following write");

  sequence s_fsb_write;
    i_wr && i_addr == `ACRS_ADDR_FS_B_HI;
  endsequence
  AST_FS_B_HI: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_fsb_write |=> o_ctrl.fs_trim_b[15:8] == $past(i_wdata))
    else $error("second trim high byte wrong");

  AST_FS_A_LO: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_FS_A_LO) |=> o_ctrl.fs_trim_a[7:0] == $past(i_wdata))
    else $error("first trim low byte wrong");

  AST_UNMAPPED: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_rd && i_addr == 8'h63) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_NO_READ: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read cycle");

  AST_STATUS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_rd && i_addr == `ACRS_ADDR_CAL_STAT) |=> o_rdata == $past(i_cal_state))
    else $error("calibration status read wrong");

  AST_CAL_EN_RB: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_CAL_EN) ##1 (i_rd && i_addr == `ACRS_ADDR_CAL_EN && !i_wr)
    |=> o_rdata == $past(i_wdata, 2))
    else $error("calibration enable readback wrong");

  // reset release: the first sampled edge after reset sees the reset map
  sequence s_reset_done;
    $fell(i_rst);
  endsequence

  // second input trim back at its default range
  AST_RST_TRIM_B: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> o_ctrl.fs_trim_b == `ACRS_RST_FS)
    else $error("second trim reset value wrong");

  // first input trim shares the same default
  AST_RST_TRIM_A: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> o_ctrl.fs_trim_a == `ACRS_RST_FS)
    else $error("first trim reset value wrong");

  // internal reference in use after reset
  AST_RST_BYPASS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> o_ctrl.ref_bypass == 1'b0)
    else $error("reference bypass set after reset");

  // timestamp receiver off and in its default mode after reset
  AST_RST_TS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> !o_ctrl.ts_recv_on && !o_ctrl.ts_pecl_sel)
    else $error("timestamp receiver not off after reset");

  // lanes start without pre-emphasis
  AST_RST_PREEMPH: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> o_ctrl.preemph == 4'h0)
    else $error("pre-emphasis not cleared by reset");

  // calibration enable defaults on
  AST_RST_CAL_EN: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> o_cal_en == `ACRS_RST_ONE)
    else $error("calibration enable reset value wrong");

  // software kick register default
  AST_RST_CAL_KICK: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> o_cal_kick == `ACRS_RST_ONE)
    else $error("calibration kick reset value wrong");

  // low-power background calibration default
  AST_RST_LOW_POWER_BACKGROUND_CAL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> o_low_power_background_cal == `ACRS_RST_LOW_POWER_BACKGROUND_CAL)
    else $error("background calibration reset value wrong");

  // readback enable defaults off
  AST_RST_CAL_DEN: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> o_cal_den == `ACRS_RST_ZERO)
    else $error("readback enable reset value wrong");

  // pin setup defaults to zero
  AST_RST_CAL_PIN: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_reset_done |-> o_cal_pin == `ACRS_RST_ZERO)
    else $error("pin setup reset value wrong");

  // low byte of the second trim follows its write, no staging
  AST_FS_B_LO: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_FS_B_LO) |=> o_ctrl.fs_trim_b[7:0] == $past(i_wdata))
    else $error("second trim low byte wrong");

  // high byte of the first trim follows its write
  AST_FS_A_HI: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_FS_A_HI) |=> o_ctrl.fs_trim_a[15:8] == $past(i_wdata))
    else $error("first trim high byte wrong");

  // kick register follows a write
  AST_CAL_KICK_WR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_CAL_KICK) |=> o_cal_kick == $past(i_wdata))
    else $error("calibration kick not following write");

  // background calibration register follows a write
  AST_LOW_POWER_BACKGROUND_CAL_WR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `ACRS_ADDR_LOW_POWER_BACKGROUND_CAL) |=> o_low_power_background_cal == $past(i_wdata))
    else $error("background calibration not following write");

  // a write that decodes to no storage, the read-only status included
  sequence s_hole_write;
    i_wr && acrs_decode(i_addr) == R_NONE;
  endsequence

  // such a write leaves every control output untouched
  AST_HOLE_WRITE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_hole_write |=> $stable(o_ctrl) && $stable(o_in_sel) && $stable(o_cal_en)
      && $stable(o_calibration_config_zero) && $stable(o_cal_pin) && $stable(o_cal_kick)
      && $stable(o_low_power_background_cal) && $stable(o_cal_den) && $stable(o_cal_data))
    else $error("write to a hole changed an output");

  // every hole reads zero, not only the first reserved address
  AST_HOLE_READ: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_rd && acrs_decode(i_addr) == R_NONE && i_addr != `ACRS_ADDR_CAL_STAT)
    |=> o_rdata == 8'h00)
    else $error("hole read not zero");

endmodule : acrs_regs
`default_nettype wire

// File: adc_config_register_slice_bench.sv
// self-checking bench for the configuration register slice
`default_nettype none
module adc_config_register_slice_bench
  import acrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_core_clk;
  logic       i_rst;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic [7:0] i_cal_state;
  logic [7:0] o_rdata;
  logic [7:0] o_in_sel;
  logic [7:0] o_cal_en;
  logic [7:0] o_calibration_config_zero;
  logic [7:0] o_cal_pin;
  logic [7:0] o_cal_kick;
  logic [7:0] o_low_power_background_cal;
  logic [7:0] o_cal_den;
  logic [7:0] o_cal_data;
  acrs_ctrl_s o_ctrl;
  logic [7:0] model [256];
  int         error_cnt;
  int         n_compared;
  int         cycles;
  int         seed_dummy;
  logic [15:0] corner [4] = '{16'hffff, 16'h2000, 16'h20ff, 16'ha000};

  acrs_regs acrs_regs_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_cal_state(i_cal_state), .o_rdata(o_rdata),
    .o_ctrl(o_ctrl), .o_in_sel(o_in_sel), .o_cal_en(o_cal_en), .o_calibration_config_zero(o_calibration_config_zero),
    .o_cal_pin(o_cal_pin), .o_cal_kick(o_cal_kick), .o_low_power_background_cal(o_low_power_background_cal),
    .o_cal_den(o_cal_den), .o_cal_data(o_cal_data)
  );

  // 250 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  // reference map: documented reset values, unmapped places read zero
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h31, 8'h33: rst_val = 8'ha0;
      8'h60, 8'h61, 8'h62, 8'h6c: rst_val = 8'h01;
      8'h6e: rst_val = 8'h88;
      default: rst_val = 8'h00;
    endcase
  endfunction : rst_val
  function automatic bit mapped(input logic [7:0] a);
    return a inside {[8'h30:8'h33], 8'h38, 8'h3b, 8'h48, 8'h60, 8'h61, 8'h62,
                     [8'h6a:8'h6c], 8'h6e, 8'h70, 8'h71};
  endfunction : mapped
  // software side: no trim below the floor, zeros in reserved bits
  function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h31, 8'h33: legal = (d < 8'h20) ? (d | 8'h20) : d;
      8'h38: legal = d & 8'h01;
      8'h3b: legal = d & 8'h03;
      8'h48: legal = d & 8'h0f;
      default: legal = d;
    endcase
  endfunction : legal
  // expected read data: status reads the live input, holes read zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == 8'h6a) return i_cal_state;
    return mapped(a) ? model[a] : 8'h00;
  endfunction : exp_rd

  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  // tasks start just after a rising edge and return just after one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    if (mapped(a) && a != 8'h6a) model[a] = d;
    @(posedge i_core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 cmp("rdata", {8'h00, exp_rd(a)}, {8'h00, o_rdata});
    @(posedge i_core_clk);
    #1 cmp("rdata idle", 16'h0000, {8'h00, o_rdata});
    @(posedge i_core_clk);
  endtask : rd
  // write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    if (mapped(a) && a != 8'h6a) model[a] = d;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 cmp("rdata b2b", {8'h00, exp_rd(a)}, {8'h00, o_rdata});
    @(posedge i_core_clk);
  endtask : wr_rd
  task automatic sweep;
    for (int a = 0; a < 256; a++) rd(8'(a));
  endtask : sweep
  task automatic check_outs;
    cmp("fs_trim_a", {model[8'h31], model[8'h30]}, o_ctrl.fs_trim_a);
    cmp("fs_trim_b", {model[8'h33], model[8'h32]}, o_ctrl.fs_trim_b);
    cmp("ref_bypass", 16'(model[8'h38][0]), 16'(o_ctrl.ref_bypass));
    cmp("ts_recv_on", 16'(model[8'h3b][0]), 16'(o_ctrl.ts_recv_on));
    cmp("ts_pecl_sel", 16'(model[8'h3b][1]), 16'(o_ctrl.ts_pecl_sel));
    cmp("preemph", 16'(model[8'h48][3:0]), 16'(o_ctrl.preemph));
    cmp("in_sel", 16'(model[8'h60]), 16'(o_in_sel));
    cmp("cal_en", 16'(model[8'h61]), 16'(o_cal_en));
    cmp("calibration_config_zero", 16'(model[8'h62]), 16'(o_calibration_config_zero));
    cmp("cal_pin", 16'(model[8'h6b]), 16'(o_cal_pin));
    cmp("cal_kick", 16'(model[8'h6c]), 16'(o_cal_kick));
    cmp("low_power_background_cal", 16'(model[8'h6e]), 16'(o_low_power_background_cal));
    cmp("cal_den", 16'(model[8'h70]), 16'(o_cal_den));
    cmp("cal_data", 16'(model[8'h71]), 16'(o_cal_data));
  endtask : check_outs
  // reset held ten cycles; model returns to documented values
  task automatic do_reset;
    i_rst <= 1'b1;
    for (int a = 0; a < 256; a++) model[a] = rst_val(8'(a));
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
  endtask : do_reset

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // hang guard, a few thousand cycles expected
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 12000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // main sequence: reset map, trim corners, random traffic, second reset
  initial begin
    logic [7:0] a;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_cal_state = 8'h5a;
    seed_dummy = $urandom(22165);
    do_reset();
    check_outs();
    sweep();
    foreach (corner[i]) begin
      wr(8'h33, corner[i][15:8]);
      wr(8'h32, corner[i][7:0]);
      wr(8'h30, corner[i][7:0]);
      check_outs();
      rd(8'h33);
    end
    for (int v = 0; v < 4; v++) begin
      wr(8'h3b, 8'(v));
      check_outs();
      rd(8'h3b);
    end
    for (int k = 8'h60; k < 8'h72; k++) begin
      wr_rd(8'(k), 8'($urandom));
      check_outs();
    end
    repeat (400) begin
      i_cal_state <= 8'($urandom);
      a = ($urandom % 2) ? 8'h30 + 8'($urandom % 66) : 8'($urandom);
      if ($urandom % 2) wr(a, legal(a, 8'($urandom)));
      else rd(a);
      check_outs();
    end
    do_reset();
    check_outs();
    sweep();
    end_of_test();
  end
endmodule : adc_config_register_slice_bench
`default_nettype wire
